// ===== map_consts.vh
/*
  Constants of the address translation and protection unit: register offsets,
  field positions, reset values and the sizes of the address spaces.
  Assumes inclusion by bare name from the unit's design files.
*/
`ifndef MAP_CONSTS_VH
`define MAP_CONSTS_VH

// Address spaces and granule.
`define MAP_LOG_W        16
`define MAP_PHYS_W       24
`define MAP_GRAN_SHIFT   8
`define MAP_GRAN_W       16
`define MAP_LEN_W        8
`define MAP_SLOT_W       2
`define MAP_SECTOR_GRANS 16'h0004

// Register offsets, byte addresses on the APB.
`define MAP_ADDR_W       12
`define MAP_OFF_CTRL     12'h000
`define MAP_OFF_STAT     12'h004
`define MAP_OFF_MASK     12'h008
`define MAP_OFF_SFRSYS   12'h00c
`define MAP_OFF_SFRAPP   12'h010
`define MAP_OFF_CLDESC   12'h014
`define MAP_OFF_FAULT    12'h018
`define MAP_OFF_DESC     12'h040
`define MAP_OFF_DESC_END 12'h07c

// Control fields.
`define MAP_CTRL_EN      0
`define MAP_CTRL_CL      1
`define MAP_CTRL_W       2

// Status and mask fields.
`define MAP_ST_RANGE     0
`define MAP_ST_SFR       1
`define MAP_ST_SECTOR    2
`define MAP_ST_W         3

// Descriptor word fields.
`define MAP_DESC_BASE_LSB 0
`define MAP_DESC_LEN_LSB  16

// Reset values.
`define MAP_CTRL_RST     2'h0
`define MAP_STAT_RST     3'h0
`define MAP_MASK_RST     3'h0
`define MAP_SFR_RST      32'h00000000
`define MAP_DESC_RST     24'h000000

`endif

// ===== map_xlate.v
/*
  One descriptor translation: physical base plus logical window offset, and
  the range check of that offset against the descriptor length.
  Assumes base and length in 256 byte granules; purely combinational.
*/
`timescale 1ns/10ps
`include "map_consts.vh"

module map_xlate
(
  // Descriptor.
  input  wire [`MAP_GRAN_W-1:0] descBase,
  input  wire [`MAP_LEN_W-1:0]  descLen,
  // Logical offset inside the 16 kByte window.
  input  wire [13:0]            winOffs,
  // Result.
  output wire [`MAP_PHYS_W-1:0] physAddr,
  output wire                   outRange
);

  assign physAddr = {descBase, 8'h00} + {10'h000, winOffs}; // RULE_04
  // A window offset at or past the length lies outside the descriptor.
  assign outRange = {2'b00, winOffs[13:8]} >= descLen;      // RULE_06

endmodule

// ===== map_sfr_check.v
/*
  Special function register rights check: one bit per hardware component,
  one rights word for system mode and one for application mode.
  Assumes the core gives a 5 bit component index with each SFR access.
*/
`timescale 1ns/10ps

module map_sfr_check
#(
  parameter COMP_W = 5
)
(
  // Rights words.
  input  wire [(1<<COMP_W)-1:0] rightsSys,
  input  wire [(1<<COMP_W)-1:0] rightsApp,
  // Access.
  input  wire                   sysMode,
  input  wire [COMP_W-1:0]      compId,
  // Result.
  output wire                   denied
);

  wire [(1<<COMP_W)-1:0] rights;

  assign rights = sysMode ? rightsSys : rightsApp; // RULE_05
  assign denied = ~rights[compId];                 // RULE_05

endmodule

// ===== map_top.v
/*
  Memory management and protection unit between the card core and the
  physical memories and special function registers.
  Assumes the core access is on clk; APB privilege comes on pprot[0].
*/
// Our own choices: the address map and the APB slave port.
// Notes on behaviour
// RULE_01: 64 kByte logical mapped into 16 MByte physical.
// RULE_02: System and application mode, separate contexts.
// RULE_03: Per mode four data, four code descriptors.
// RULE_04: Descriptor base and length in 256 byte.
// RULE_05: Two rights words guard component SFR accesses.
// RULE_06: Out of range access raises non-maskable interrupt.
// RULE_07: Descriptor table reachable only from system mode.
// RULE_08: After reset transparent, no checks, until enabled.
// RULE_09: System software must enable protection after reset.
// RULE_10: Contactless mode adds descriptor opening reserved sector.
// RULE_11: Rights set by software apply to every access.
// RULE_12: Violating access blocked before the interrupt appears.
`timescale 1ns/10ps
`include "map_consts.vh"

module map_top
#(
  parameter COMP_W      = 5,
  parameter SECTOR_BASE = 16'h0100
)
(
  // Clock and reset.
  input  wire                    clk,
  input  wire                    sys_rst,
  // APB register port.
  input  wire                    psel,
  input  wire                    penable,
  input  wire                    pwrite,
  input  wire [`MAP_ADDR_W-1:0]  paddr,
  input  wire [31:0]             pwdata,
  input  wire [2:0]              pprot,
  output wire [31:0]             prdata,
  output wire                    pready,
  output wire                    pslverr,
  // Core access.
  input  wire                    cpuReq,
  input  wire                    cpuWr,
  input  wire                    cpuCode,
  input  wire                    cpuSfr,
  input  wire                    cpuSysMode,
  input  wire [`MAP_LOG_W-1:0]   cpuAddr,
  input  wire [COMP_W-1:0]       cpuCompId,
  // Physical side.
  output wire                    memReq,
  output wire                    memWr,
  output wire                    memSfr,
  output wire [`MAP_PHYS_W-1:0]  memAddr,
  // Interrupts.
  output wire                    nmi,
  output wire                    irq
);

  localparam NCOMP = 1 << COMP_W;

  // Registers.
  reg [`MAP_CTRL_W-1:0]  ctrl_ff;
  reg [`MAP_ST_W-1:0]    stat_ff;
  reg [`MAP_ST_W-1:0]    mask_ff;
  reg [NCOMP-1:0]        sfrSys_ff;
  reg [NCOMP-1:0]        sfrApp_ff;
  reg [23:0]             clDesc_ff;
  reg [`MAP_LOG_W-1:0]   fault_ff;
  reg [23:0]             desc_ff [0:15];
  reg [31:0]             prdata_ff;
  reg                    pready_ff;
  reg                    pslverr_ff;
  reg                    memReq_ff;
  reg                    memWr_ff;
  reg                    memSfr_ff;
  reg [`MAP_PHYS_W-1:0]  memAddr_ff;
  reg                    nmiPend_ff;
  reg                    nmi_ff;
  reg                    irq_ff;

  // Bus decode.
  wire       setup;
  wire       access;
  wire       busPriv;
  wire       wrDone;
  reg [31:0] nxt_prdata;
  reg        nxt_pslverr;

  // Translation.
  wire [3:0]             descIdx;
  wire                   useCl;
  wire [23:0]            selDesc;
  wire [`MAP_PHYS_W-1:0] xlAddr;
  wire                   xlOut;
  wire                   sfrDenied;
  wire                   enabled;
  wire                   sectorHit;
  wire                   violRange;
  wire                   violSfr;
  wire                   violSector;
  wire                   violAny;
  wire [`MAP_ST_W-1:0]   evSet;
  wire [`MAP_ST_W-1:0]   w1c;
  wire [`MAP_ST_W-1:0]   nxt_stat;

  integer i;

  function isDesc;
    input [`MAP_ADDR_W-1:0] a;
    begin
      isDesc = (a >= `MAP_OFF_DESC) && (a <= `MAP_OFF_DESC_END) && (a[1:0] == 2'b00);
    end
  endfunction

  function isMapped;
    input [`MAP_ADDR_W-1:0] a;
    begin
      isMapped = isDesc(a) || (a == `MAP_OFF_CTRL) || (a == `MAP_OFF_STAT) ||
                 (a == `MAP_OFF_MASK) || (a == `MAP_OFF_SFRSYS) ||
                 (a == `MAP_OFF_SFRAPP) || (a == `MAP_OFF_CLDESC) ||
                 (a == `MAP_OFF_FAULT);
    end
  endfunction

  assign setup   = psel & ~penable;
  assign access  = psel & penable & pready_ff;
  // The whole map is privileged, so application code can never retarget itself.
  assign busPriv = pprot[0];                                         // RULE_07
  assign wrDone  = access & pwrite & busPriv & isMapped(paddr);      // RULE_07

  // Read data and error are prepared in the setup cycle and held for access.
  always @*
  begin
    nxt_prdata  = 32'h00000000;
    nxt_pslverr = 1'b0;
    if (!busPriv || !isMapped(paddr))
      nxt_pslverr = 1'b1;                                            // RULE_07
    else if (isDesc(paddr))
      nxt_prdata = {8'h00, desc_ff[paddr[5:2]]};
    else
    begin
      case (paddr)
        `MAP_OFF_CTRL:   nxt_prdata = {30'h00000000, ctrl_ff};
        `MAP_OFF_STAT:   nxt_prdata = {29'h00000000, stat_ff};
        `MAP_OFF_MASK:   nxt_prdata = {29'h00000000, mask_ff};
        `MAP_OFF_SFRSYS: nxt_prdata = sfrSys_ff;
        `MAP_OFF_SFRAPP: nxt_prdata = sfrApp_ff;
        `MAP_OFF_CLDESC: nxt_prdata = {8'h00, clDesc_ff};
        `MAP_OFF_FAULT:  nxt_prdata = {16'h0000, fault_ff};
        default:         nxt_prdata = 32'h00000000;
      endcase
    end
  end

  // Every transfer gets exactly one access cycle; pready never waits, so the
  // read path needs no second stage.
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      prdata_ff  <= 32'h00000000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      pready_ff <= setup & ~pready_ff;
      if (setup)
      begin
        prdata_ff  <= pwrite ? 32'h00000000 : nxt_prdata;
        pslverr_ff <= nxt_pslverr;
      end
    end
  end

  // Software-written configuration.
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctrl_ff   <= `MAP_CTRL_RST;                                    // RULE_08
      mask_ff   <= `MAP_MASK_RST;
      sfrSys_ff <= `MAP_SFR_RST;
      sfrApp_ff <= `MAP_SFR_RST;
      clDesc_ff <= `MAP_DESC_RST;
      for (i = 0; i < 16; i = i + 1)
        desc_ff[i] <= `MAP_DESC_RST;
    end
    else if (wrDone)
    begin
      if (isDesc(paddr))
        desc_ff[paddr[5:2]] <= pwdata[23:0];                         // RULE_03
      case (paddr)
        `MAP_OFF_CTRL:   ctrl_ff   <= pwdata[`MAP_CTRL_W-1:0];       // RULE_11
        `MAP_OFF_MASK:   mask_ff   <= pwdata[`MAP_ST_W-1:0];
        `MAP_OFF_SFRSYS: sfrSys_ff <= pwdata;                        // RULE_05
        `MAP_OFF_SFRAPP: sfrApp_ff <= pwdata;                        // RULE_05
        `MAP_OFF_CLDESC: clDesc_ff <= pwdata[23:0];                  // RULE_10
        default:         ctrl_ff   <= ctrl_ff;
      endcase
    end
  end

  // Until software sets the enable bit every access passes unchecked and
  // untranslated.
  assign enabled = ctrl_ff[`MAP_CTRL_EN];                            // RULE_08

  // Table index: mode, access type, then the logical window.
  assign descIdx = {~cpuSysMode, cpuCode, cpuAddr[15:14]};           // RULE_02
  // The contactless descriptor replaces the last data window in that mode.
  assign useCl   = ctrl_ff[`MAP_CTRL_CL] & ~cpuCode & (cpuAddr[15:14] == 2'b11); // RULE_10
  assign selDesc = useCl ? clDesc_ff : desc_ff[descIdx];             // RULE_03

  map_xlate u_xlate
  (
    .descBase (selDesc[`MAP_DESC_LEN_LSB-1:`MAP_DESC_BASE_LSB]),
    .descLen  (selDesc[`MAP_DESC_LEN_LSB+`MAP_LEN_W-1:`MAP_DESC_LEN_LSB]),
    .winOffs  (cpuAddr[13:0]),
    .physAddr (xlAddr),
    .outRange (xlOut)
  );

  map_sfr_check #(.COMP_W(COMP_W)) u_sfr
  (
    .rightsSys (sfrSys_ff),
    .rightsApp (sfrApp_ff),
    .sysMode   (cpuSysMode),
    .compId    (cpuCompId),
    .denied    (sfrDenied)
  );

  // The reserved sector is 1 kByte; only the contactless descriptor reaches it.
  assign sectorHit  = (xlAddr[`MAP_PHYS_W-1:8] >= SECTOR_BASE) &&
                      (xlAddr[`MAP_PHYS_W-1:8] < SECTOR_BASE + `MAP_SECTOR_GRANS);
  assign violRange  = enabled & cpuReq & ~cpuSfr & xlOut;            // RULE_06
  assign violSfr    = enabled & cpuReq & cpuSfr & sfrDenied;         // RULE_05
  assign violSector = enabled & cpuReq & ~cpuSfr & ~xlOut & sectorHit & ~useCl; // RULE_10
  assign violAny    = violRange | violSfr | violSector;              // RULE_11

  // Physical access; a violating access never leaves the unit.
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      memReq_ff  <= 1'b0;
      memWr_ff   <= 1'b0;
      memSfr_ff  <= 1'b0;
      memAddr_ff <= 24'h000000;
    end
    else
    begin
      memReq_ff <= cpuReq & ~violAny;                                // RULE_12
      memWr_ff  <= cpuReq & cpuWr & ~violAny;                        // RULE_12
      memSfr_ff <= cpuReq & cpuSfr & ~violAny;
      // The address follows every request, a refused one too; memReq alone
      // qualifies it, so a refused address never reaches a memory.
      if (cpuReq)
      begin
        if (!enabled || cpuSfr)
          memAddr_ff <= {8'h00, cpuAddr};                            // RULE_08
        else
          memAddr_ff <= xlAddr;                                      // RULE_01
      end
    end
  end

  // Sticky status; a new event wins over a clear in the same cycle.
  assign evSet    = {violSector, violSfr, violRange};
  assign w1c      = (wrDone && paddr == `MAP_OFF_STAT) ? pwdata[`MAP_ST_W-1:0] : 3'h0;
  assign nxt_stat = (stat_ff & ~w1c) | evSet;

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      stat_ff    <= `MAP_STAT_RST;
      fault_ff   <= 16'h0000;
      nmiPend_ff <= 1'b0;
      nmi_ff     <= 1'b0;
      irq_ff     <= 1'b0;
    end
    else
    begin
      stat_ff    <= nxt_stat;
      if (violAny)
        fault_ff <= cpuAddr;
      // The interrupt trails the blocked access by a cycle, so the block is seen first.
      nmiPend_ff <= violAny;                                         // RULE_12
      nmi_ff     <= nmiPend_ff;                                      // RULE_06
      irq_ff     <= |(nxt_stat & mask_ff);
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign memReq  = memReq_ff;
  assign memWr   = memWr_ff;
  assign memSfr  = memSfr_ff;
  assign memAddr = memAddr_ff;
  assign nmi     = nmi_ff;
  assign irq     = irq_ff;

endmodule

// ===== map_top_properties.sv
/* Port assertions for map_top.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/10ps
module map_top_properties
(
  // Clock and reset.
  input wire logic        clk,
  input wire logic        sys_rst,
  // Register port.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [2:0]  pprot,
  input wire logic        pready,
  input wire logic        pslverr,
  // Core and memory side.
  input wire logic        cpuReq,
  input wire logic        cpuWr,
  input wire logic        cpuSfr,
  input wire logic [15:0] cpuAddr,
  input wire logic        memReq,
  input wire logic        memWr,
  input wire logic        memSfr,
  input wire logic [23:0] memAddr,
  input wire logic        nmi,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_grant_cause: assert property (memReq |-> $past(cpuReq))
    else $error("grant without request");
  chk_refuse_nmi: assert property (cpuReq ##1 !memReq |=> nmi)
    else $error("refused access without nmi");
  chk_nmi_cause: assert property (nmi |-> $past(cpuReq, 2) && !$past(memReq))
    else $error("nmi without blocked access");
  chk_nmi_pulse: assert property (nmi && !$past(cpuReq) |=> !nmi)
    else $error("nmi longer than one cycle");
  chk_low_bits: assert property (memReq |-> memAddr[7:0] == $past(cpuAddr[7:0]))
    else $error("granule offset changed");
  chk_dir_kept: assert property (memReq |-> memWr == $past(cpuWr) && memSfr == $past(cpuSfr))
    else $error("access kind changed");
  chk_apb_priv: assert property (psel && !penable && !pprot[0] |=> pready && pslverr)
    else $error("unprivileged access accepted");
  chk_apb_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_irq_clear: assert property ($fell(irq) |-> $past(psel && pwrite) || $past(psel && pwrite, 2))
    else $error("irq fell without write");
endmodule

bind map_top map_top_properties u_map_top_properties (.clk(clk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pprot(pprot), .pready(pready), .pslverr(pslverr),
  .cpuReq(cpuReq), .cpuWr(cpuWr), .cpuSfr(cpuSfr), .cpuAddr(cpuAddr), .memReq(memReq),
  .memWr(memWr), .memSfr(memSfr), .memAddr(memAddr), .nmi(nmi), .irq(irq));

// ===== map_core_model.sv
/* Core access port model: one access per go cycle.
   Assumes the bench drives its commands on the rising edge. */
`timescale 1ns/10ps
module map_core_model
(
  // Clock, reset and command.
  input wire logic         clk,
  input wire logic         sys_rst,
  input wire logic         go,
  input wire logic [24:0]  cmd,
  // Core access port.
  output logic             cpuReq,
  output logic             cpuWr,
  output logic             cpuCode,
  output logic             cpuSfr,
  output logic             cpuSysMode,
  output logic [15:0]      cpuAddr,
  output logic [4:0]       cpuCompId
);
  // Between accesses the address toggles so no stale value looks valid.
  always @(posedge clk)
    if (sys_rst)
      {cpuReq, cpuSysMode, cpuCode, cpuSfr, cpuWr, cpuAddr, cpuCompId} <= 26'h0;
    else if (go)
      {cpuReq, cpuSysMode, cpuCode, cpuSfr, cpuWr, cpuAddr, cpuCompId} <= {1'b1, cmd};
    else
    begin
      cpuReq  <= 1'b0;
      cpuAddr <= ~cpuAddr;
    end
endmodule

// ===== tb_map_top.sv
/* Self-checking bench for map_top over APB and the core port.
   Assumes the core model answers one cycle after go. */
`timescale 1ns/10ps
module tb_map_top;
  localparam logic [15:0] SB = 16'h0100;
  logic clk, sys_rst, psel, penable, pwrite, go, mq, mw, ms, nm, err;
  logic [3:0]  lk;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [2:0]  pprot;
  logic [24:0] cmd;
  logic [23:0] ma;
  wire  [31:0] prdata;
  wire  [23:0] memAddr;
  wire  [15:0] cpuAddr;
  wire  [4:0]  cpuCompId;
  wire pready, pslverr, cpuReq, cpuWr, cpuCode, cpuSfr, cpuSysMode, memReq, memWr, memSfr, nmi, irq;
  int miscompares = 0, comparisons = 0, cyc = 0;
  map_top #(.COMP_W(5), .SECTOR_BASE(SB)) u_map_top (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pprot(pprot),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpuReq(cpuReq), .cpuWr(cpuWr),
    .cpuCode(cpuCode), .cpuSfr(cpuSfr), .cpuSysMode(cpuSysMode), .cpuAddr(cpuAddr),
    .cpuCompId(cpuCompId), .memReq(memReq), .memWr(memWr), .memSfr(memSfr), .memAddr(memAddr),
    .nmi(nmi), .irq(irq));
  map_core_model u_map_core_model (.clk(clk), .sys_rst(sys_rst), .go(go), .cmd(cmd),
    .cpuReq(cpuReq), .cpuWr(cpuWr), .cpuCode(cpuCode), .cpuSfr(cpuSfr),
    .cpuSysMode(cpuSysMode), .cpuAddr(cpuAddr), .cpuCompId(cpuCompId));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task end_sim;
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic p);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata, pprot} <= {2'b10, w, a, d, 2'b00, p};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Fields: system mode, code, sfr, write, address, component.
  task acc(input logic [3:0] k, input logic [15:0] a, input logic [4:0] id);
    @(posedge clk);
    go <= 1'b1;
    cmd <= {k, a, id};
    lk = k;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    {mq, mw, ms, ma} = {memReq, memWr, memSfr, memAddr};
    @(negedge clk);
    nm = nmi;
  endtask
  task grant(input logic [23:0] e);
    chk({4'h0, nm, mq, ms, mw, ma}, {4'h0, 2'b01, lk[1:0], e});
  endtask
  task deny;
    chk({28'h0, nm, mq, ms, mw}, 32'h00000008);
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      miscompares++;
      end_sim;
    end
  end
  initial
  begin
    {sys_rst, psel, penable, pwrite, go, paddr, pwdata, pprot, cmd} <= {1'b1, 76'h0};
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    acc(4'h1, 16'hbeef, 5'h00); grant(24'h00beef);
    apb(1'b1, 12'h044, 32'h1, 1'b0); chk(err, 32'h1);
    apb(0, 12'h044, 0, 1'b1); chk(rd, 32'h0);
    apb(0, 12'h020, 0, 1'b1);
    chk(err, 32'h1);
    chk(rd, 32'h0);
    $display("test access done");
    apb(1'b1, 12'h044, 32'h00101234, 1'b1);
    apb(1'b1, 12'h070, 32'h00400200, 1'b1);
    apb(1'b1, 12'h008, 32'h7, 1'b1);
    apb(1'b1, 12'h000, 32'h1, 1'b1);
    acc(4'h8, 16'h4005, 5'h00); grant(24'h123405);
    acc(4'h9, 16'h4fff, 5'h00); grant(24'h1243ff);
    acc(4'h8, 16'h5000, 5'h00); deny();
    chk(irq, 32'h1);
    apb(0, 12'h004, 0, 1'b1); chk(rd, 32'h1);
    apb(0, 12'h018, 0, 1'b1); chk(rd, 32'h5000);
    apb(1'b1, 12'h004, 32'h1, 1'b1);
    repeat (2) @(posedge clk);
    chk(irq, 32'h0);
    acc(4'h4, 16'h0123, 5'h00); grant(24'h020123);
    acc(4'h0, 16'h0123, 5'h00); deny();
    $display("test translate done");
    acc(4'ha, 16'h0090, 5'h03); deny();
    apb(1'b1, 12'h00c, 32'h8, 1'b1);
    acc(4'ha, 16'h0090, 5'h03); grant(24'h000090);
    acc(4'h2, 16'h0090, 5'h03); deny();
    $display("test sfr done");
    apb(1'b1, 12'h04c, {16'h0004, SB}, 1'b1);
    acc(4'h8, 16'hc010, 5'h00); deny();
    apb(1'b1, 12'h014, {16'h0004, SB}, 1'b1);
    apb(1'b1, 12'h000, 32'h3, 1'b1);
    acc(4'h9, 16'hc010, 5'h00); grant({SB, 8'h10});
    apb(0, 12'h004, 0, 1'b1); chk(rd, 32'h7);
    $display("test sector done");
    end_sim;
  end
endmodule
